// >>> shared/rtc_pkg.sv
// package: constants and types of the rtc serial front end
// Notes on behaviour
// [RL1] the device only answers on the serial bus and never starts a transfer
// [RL2] the master opens each access with start, then the id code, then data
// [RL3] later registers follow one after another in a transfer until stop
// [RL4] enabled alarm 1 match pulls the first open-drain interrupt pin low
// [RL5] second open-drain pin is either square wave or interrupt output
// [RL6] the timebase is a 32.768 khz source on the oscillator input
// [RL7] in a multibyte access the pointer wraps from the last location to zero
// [RL8] time is copied to read buffers on start, stop and pointer wrap
// [RL9] interrupt control selects separate or shared alarm interrupt outputs
// [RL10] a written byte lands in its register at the device acknowledge
// [RL11] the pointer advances by one after every data byte read or written
package rtc_pkg;
  localparam int OSC_HZ = 32768;
  localparam logic [3:0] ADR_SEC = 4'h0;
  localparam logic [3:0] ADR_MIN = 4'h1;
  localparam logic [3:0] ADR_TIME_LAST = 4'h6;
  localparam logic [3:0] ADR_A1_SEC = 4'h7;
  localparam logic [3:0] ADR_A2_MIN = 4'hB;
  localparam logic [3:0] ADR_CTRL = 4'hE;
  localparam logic [3:0] ADR_STAT = 4'hF;
  localparam int CTRL_A1IE = 0;
  localparam int CTRL_A2IE = 1;
  localparam int CTRL_IRQ_CONTROL_SELECT = 2;
  localparam int STAT_A1F = 0;
  localparam int STAT_A2F = 1;
  localparam logic [7:0] BCD_59 = 8'h3B + 8'h1E;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  // id code value is arbitrary
  localparam logic [6:0] DEV_ID_DEF = 7'h2A;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK = 6'h04,
    ST_RX = 6'h08,
    ST_TX = 6'h10,
    ST_MACK = 6'h20
  } rtc_state_type;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } rtc_wr_type;
endpackage

// >>> verilog/rtc_serial_core.sv
// serial slave front end, timebase divider, write fifo and alarm pins
`timescale 1ns/1ns
module rtc_fifo #(
  parameter int W = 12,
  parameter int D = 8
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] n;
  } rtc_fifo_type;
  rtc_fifo_type q;
  rtc_fifo_type d;
  logic push;
  logic pop;
  if (D < 2 || (1 << AW) != D || W < 1)
  begin : g_bad
    $error("fifo depth must be a power of two of at least 2");
  end
  assign in_ready_o = q.n != (AW+1)'(D);
  assign out_valid_o = q.n != '0;
  assign out_data_o = q.mem[q.rp];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wp] = in_data_i;
      d.wp = AW'(q.wp + 1'b1);
    end
    if (pop)
      d.rp = AW'(q.rp + 1'b1);
    if (push & ~pop)
      d.n = (AW+1)'(q.n + 1'b1);
    else if (pop & ~push)
      d.n = (AW+1)'(q.n - 1'b1);
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      q <= '0;
    else
      q <= d;
  end
endmodule // rtc_fifo

module rtc_osc_div #(
  parameter int HALF_COUNT = rtc_pkg::OSC_HZ / 2
) (
  input wire logic osc_in_i,
  input wire logic nrst_i,
  output logic sq_o
);
  localparam int CW = (HALF_COUNT > 1) ? $clog2(HALF_COUNT) : 1;
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic lvl;
  } rtc_osc_type;
  rtc_osc_type q;
  rtc_osc_type d;
  if (HALF_COUNT < 1)
  begin : g_bad
    $error("half period count must be at least one");
  end
  assign sq_o = q.lvl;
  always_comb
  begin
    d = q;
    if (q.cnt == CW'(HALF_COUNT - 1))
    begin
      d.cnt = '0;
      d.lvl = ~q.lvl; // RL6
    end
    else
      d.cnt = CW'(q.cnt + 1'b1);
  end
  always_ff @(posedge osc_in_i or negedge nrst_i)
  begin
    if (!nrst_i)
      q <= '0;
    else
      q <= d;
  end
  chk_osc_range: assert property (@(posedge osc_in_i) disable iff (!nrst_i)
    q.cnt <= CW'(HALF_COUNT - 1)) // RL6
    else $error("timebase counter past its half period");
endmodule // rtc_osc_div

module rtc_serial_core #(
  parameter logic [6:0] DEV_ID = rtc_pkg::DEV_ID_DEF,
  parameter int HALF_COUNT = rtc_pkg::OSC_HZ / 2,
  parameter int DEPTH = rtc_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic osc_in_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic alarm_irq_a_n_o,
  output logic alarm_irq_a_n_oe_o,
  output logic square_wave_or_irq_b_o,
  output logic square_wave_or_irq_b_oe_o
);
  localparam int TL = int'(rtc_pkg::ADR_TIME_LAST);
  typedef struct packed {
    rtc_pkg::rtc_state_type st;
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    logic [2:0] sq_sy;
    logic scl;
    logic sda;
    logic sq;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [3:0] ptr;
    logic rw;
    logic first;
    logic sda_oe;
    logic oe_a;
    logic oe_b;
    logic [15:0][7:0] regs;
    logic [TL:0][7:0] shadow;
  } rtc_core_type;
  // serial pins idle high, so their stages start high: no false edge
  localparam rtc_core_type RST = '{st: rtc_pkg::ST_IDLE, scl_sy: 3'h7,
    sda_sy: 3'h7, scl: 1'b1, sda: 1'b1, default: '0};
  rtc_core_type q;
  rtc_core_type d;
  logic sq_osc;
  logic ev_start;
  logic ev_stop;
  logic fall;
  logic tick;
  logic ia;
  logic ib;
  logic irq_control_select;
  logic fifo_in_valid;
  logic fifo_in_ready;
  rtc_pkg::rtc_wr_type fifo_in;
  logic fifo_out_valid;
  logic fifo_out_ready;
  rtc_pkg::rtc_wr_type fifo_out;
  logic [TL:0][7:0] time_now;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v,
                                         input logic [7:0] last);
    if (v == last)
      return '0;
    else if (v[3:0] == 4'h9)
      return {4'(v[7:4] + 4'h1), 4'h0};
    else
      return 8'(v + 8'h01);
  endfunction

  function automatic logic [7:0] rd_byte(input rtc_core_type s,
                                         input logic [3:0] a);
    if (a <= rtc_pkg::ADR_TIME_LAST)
      return s.shadow[a[2:0]];
    else
      return s.regs[a];
  endfunction

  rtc_osc_div #(.HALF_COUNT(HALF_COUNT)) u_rtc_osc_div (
    .osc_in_i(osc_in_i),
    .nrst_i(nrst_i),
    .sq_o(sq_osc)
  );

  rtc_fifo #(.W($bits(rtc_pkg::rtc_wr_type)), .D(DEPTH)) u_rtc_fifo (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out)
  );

  assign time_now = q.regs[TL:0];
  assign irq_control_select = q.regs[rtc_pkg::ADR_CTRL][rtc_pkg::CTRL_IRQ_CONTROL_SELECT];
  assign ia = q.regs[rtc_pkg::ADR_CTRL][rtc_pkg::CTRL_A1IE]
    & q.regs[rtc_pkg::ADR_STAT][rtc_pkg::STAT_A1F];
  assign ib = q.regs[rtc_pkg::ADR_CTRL][rtc_pkg::CTRL_A2IE]
    & q.regs[rtc_pkg::ADR_STAT][rtc_pkg::STAT_A2F];
  assign sda_o = 1'b0;
  assign sda_oe_o = q.sda_oe;
  assign alarm_irq_a_n_o = 1'b0;
  assign alarm_irq_a_n_oe_o = q.oe_a;
  assign square_wave_or_irq_b_o = 1'b0;
  assign square_wave_or_irq_b_oe_o = q.oe_b;

  always_comb
  begin
    logic nscl;
    logic nsda;
    logic nsq;
    logic rise;
    logic wrap;
    logic [7:0] sec;
    logic [7:0] mins;
    logic [7:0] rb;
    nscl = 1'b0;
    nsda = 1'b0;
    nsq = 1'b0;
    rise = 1'b0;
    wrap = 1'b0;
    sec = '0;
    mins = '0;
    rb = rd_byte(q, q.ptr);
    d = q;
    fifo_in_valid = 1'b0;
    fifo_in = '{addr: q.ptr, data: q.sh};
    // inputs from other domains settle once two stages agree
    d.scl_sy = {q.scl_sy[1:0], scl_i};
    d.sda_sy = {q.sda_sy[1:0], sda_i};
    d.sq_sy = {q.sq_sy[1:0], sq_osc};
    nscl = (q.scl_sy[1] == q.scl_sy[2]) ? q.scl_sy[2] : q.scl;
    nsda = (q.sda_sy[1] == q.sda_sy[2]) ? q.sda_sy[2] : q.sda;
    nsq = (q.sq_sy[1] == q.sq_sy[2]) ? q.sq_sy[2] : q.sq;
    d.scl = nscl;
    d.sda = nsda;
    d.sq = nsq;
    rise = nscl & ~q.scl;
    fall = ~nscl & q.scl;
    ev_start = q.scl & nscl & q.sda & ~nsda;
    ev_stop = q.scl & nscl & ~q.sda & nsda;
    tick = nsq & ~q.sq;
    // register writes wait while the time advances
    fifo_out_ready = ~tick;
    case (q.st)
      rtc_pkg::ST_IDLE:
        d.sda_oe = 1'b0; // RL1
      rtc_pkg::ST_ADDR:
      begin
        if (rise)
        begin
          d.sh = {q.sh[6:0], nsda};
          d.cnt = 4'(q.cnt + 4'h1);
        end
        else if (fall && q.cnt == rtc_pkg::BYTE_BITS)
        begin
          d.cnt = '0;
          if (q.sh[7:1] == DEV_ID) // RL2
          begin
            d.rw = q.sh[0];
            d.sda_oe = 1'b1;
            d.st = rtc_pkg::ST_ACK;
          end
          else
            d.st = rtc_pkg::ST_IDLE;
        end
      end
      rtc_pkg::ST_ACK:
        if (fall)
        begin
          d.cnt = '0;
          if (q.rw)
          begin
            d.st = rtc_pkg::ST_TX;
            d.sh = rb;
            d.sda_oe = ~rb[7];
          end
          else
          begin
            d.st = rtc_pkg::ST_RX;
            d.sda_oe = 1'b0;
          end
        end
      rtc_pkg::ST_RX:
        if (rise)
        begin
          d.sh = {q.sh[6:0], nsda};
          d.cnt = 4'(q.cnt + 4'h1);
        end
        else if (fall && q.cnt == rtc_pkg::BYTE_BITS)
        begin
          d.cnt = '0;
          d.st = rtc_pkg::ST_ACK;
          d.sda_oe = 1'b1;
          if (q.first)
          begin
            d.first = 1'b0;
            d.ptr = q.sh[3:0];
          end
          else if (fifo_in_ready)
          begin
            fifo_in_valid = 1'b1; // RL10
            d.ptr = 4'(q.ptr + 4'h1); // RL11
            wrap = q.ptr == rtc_pkg::ADR_STAT; // RL7
          end
          else
          begin
            d.st = rtc_pkg::ST_IDLE;
            d.sda_oe = 1'b0;
          end
        end
      rtc_pkg::ST_TX:
        if (fall)
        begin
          if (q.cnt == rtc_pkg::LAST_BIT)
          begin
            d.sda_oe = 1'b0;
            d.st = rtc_pkg::ST_MACK;
            d.ptr = 4'(q.ptr + 4'h1); // RL3 RL11
            wrap = q.ptr == rtc_pkg::ADR_STAT; // RL7
          end
          else
          begin
            d.cnt = 4'(q.cnt + 4'h1);
            d.sh = {q.sh[6:0], 1'b0};
            d.sda_oe = ~q.sh[6];
          end
        end
      rtc_pkg::ST_MACK:
        if (rise && nsda)
          d.st = rtc_pkg::ST_IDLE;
        else if (fall)
        begin
          d.st = rtc_pkg::ST_TX;
          d.cnt = '0;
          d.sh = rb;
          d.sda_oe = ~rb[7];
        end
      default:
        d.st = rtc_pkg::ST_IDLE;
    endcase
    if (ev_start)
    begin
      d.st = rtc_pkg::ST_ADDR; // RL2
      d.cnt = '0;
      d.first = 1'b1;
      d.sda_oe = 1'b0;
    end
    if (ev_stop)
    begin
      d.st = rtc_pkg::ST_IDLE; // RL3
      d.sda_oe = 1'b0;
    end
    if (ev_start | ev_stop | wrap)
      d.shadow = time_now; // RL8
    if (tick)
    begin
      sec = bcd_inc(q.regs[rtc_pkg::ADR_SEC], rtc_pkg::BCD_59);
      d.regs[rtc_pkg::ADR_SEC] = sec;
      if (sec[6:0] == q.regs[rtc_pkg::ADR_A1_SEC][6:0])
        d.regs[rtc_pkg::ADR_STAT][rtc_pkg::STAT_A1F] = 1'b1; // RL4
      if (sec == '0)
      begin
        mins = bcd_inc(q.regs[rtc_pkg::ADR_MIN], rtc_pkg::BCD_59);
        d.regs[rtc_pkg::ADR_MIN] = mins;
        if (mins[6:0] == q.regs[rtc_pkg::ADR_A2_MIN][6:0])
          d.regs[rtc_pkg::ADR_STAT][rtc_pkg::STAT_A2F] = 1'b1;
      end
    end
    else if (fifo_out_valid)
    begin
      // flags only clear by writing zero; never in a setting cycle
      if (fifo_out.addr == rtc_pkg::ADR_STAT)
        d.regs[rtc_pkg::ADR_STAT] = q.regs[rtc_pkg::ADR_STAT]
          & fifo_out.data;
      else
        d.regs[fifo_out.addr] = fifo_out.data; // RL10
    end
    d.oe_a = ia | (ib & ~irq_control_select); // RL4 RL9
    d.oe_b = irq_control_select ? ib : ~q.sq; // RL5 RL9
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      q <= RST;
    else
      q <= d;
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  chk_idle_quiet: assert property ( // RL1
    q.st == rtc_pkg::ST_IDLE |-> !q.sda_oe)
    else $error("data line driven while idle");
  chk_start_addr: assert property ( // RL2
    ev_start |=> q.st == rtc_pkg::ST_ADDR && !q.sda_oe)
    else $error("start did not open address phase");
  chk_seq_read: assert property ( // RL3
    q.st == rtc_pkg::ST_TX && fall && q.cnt == rtc_pkg::LAST_BIT
    |=> q.st == rtc_pkg::ST_MACK && q.ptr == $past(q.ptr) + 4'h1)
    else $error("read did not move to next register");
  chk_ptr_step: assert property ( // RL11
    fifo_in_valid |=> q.ptr == $past(q.ptr) + 4'h1 && fifo_out_valid)
    else $error("pointer did not advance after write");
  chk_ptr_wrap: assert property ( // RL7
    fifo_in_valid && q.ptr == rtc_pkg::ADR_STAT |=> q.ptr == 4'h0)
    else $error("pointer did not wrap to zero");
  chk_snap_copy: assert property ( // RL8
    ev_start || ev_stop |=> q.shadow == $past(time_now))
    else $error("time not copied to read buffer");
  chk_write_commit: assert property ( // RL10
    fifo_out_valid && fifo_out_ready
    && fifo_out.addr != rtc_pkg::ADR_STAT
    |=> q.regs[$past(fifo_out.addr)] == $past(fifo_out.data))
    else $error("written byte not stored");
  chk_irq_a_pin: assert property ( // RL4
    ia |=> q.oe_a)
    else $error("first interrupt pin not pulled low");
  chk_irq_b_mode: assert property ( // RL5 RL9
    irq_control_select |=> q.oe_b == $past(ib) && (q.oe_a == $past(ia)))
    else $error("separate interrupt mode wrong");
  chk_sq_wave: assert property ( // RL5
    !irq_control_select |=> q.oe_b == !$past(q.sq))
    else $error("square wave not on second pin");
endmodule // rtc_serial_core

// >>> verification/rtc_i2c_master.sv
// partner model: serial bus master driving the clock line high and low and pulling the data line low
`timescale 1ns/1ns
module rtc_i2c_master (
  input wire logic clk_sys_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic ph(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask
  // start or repeated start; data moves 3 cycles after the clock fall
  task automatic start_c();
    ph(3);
    sda_low_o = 1'b0;
    ph(7);
    scl_o = 1'b1;
    ph(10);
    sda_low_o = 1'b1;
    ph(10);
    scl_o = 1'b0;
  endtask
  task automatic stop_c();
    ph(3);
    sda_low_o = 1'b1;
    ph(7);
    scl_o = 1'b1;
    ph(10);
    sda_low_o = 1'b0;
    ph(10);
  endtask
  task automatic bit_c(input logic b, output logic r);
    ph(3);
    sda_low_o = ~b;
    ph(7);
    scl_o = 1'b1;
    ph(10);
    r = sda_i;
    scl_o = 1'b0;
  endtask
  // msb first, then the ninth bit; released line reads the pull-up
  task automatic xfer(input logic [7:0] tx, input logic ab,
                      output logic [7:0] rx, output logic ak);
    for (int i = 7; i >= 0; i--)
      bit_c(tx[i], rx[i]);
    bit_c(ab, ak);
  endtask
endmodule // rtc_i2c_master

// >>> verification/test_rtc_serial_core.sv
// testbench: serial access, timebase and interrupt pins of the core
`timescale 1ns/1ns
module test_rtc_serial_core;
  localparam int H = 50;
  logic clk_sys_i, nrst_i, osc, scl, sda_low, sda_oe, a_oe, b_oe;
  logic [7:0] r0, r1, r2;
  logic sda_d, a_d, b_d;
  int fails, num_checks, cyc, osc_left;
  wire sda;
  // open drain with pull-up: low while any party pulls
  assign sda = ~(sda_low | sda_oe);
  rtc_serial_core #(.HALF_COUNT(H)) u_rtc_serial_core (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .osc_in_i(osc),
    .scl_i(scl),
    .sda_i(sda),
    .sda_o(sda_d),
    .sda_oe_o(sda_oe),
    .alarm_irq_a_n_o(a_d),
    .alarm_irq_a_n_oe_o(a_oe),
    .square_wave_or_irq_b_o(b_d),
    .square_wave_or_irq_b_oe_o(b_oe)
  );
  rtc_i2c_master u_mst (
    .clk_sys_i(clk_sys_i),
    .sda_i(sda),
    .scl_o(scl),
    .sda_low_o(sda_low)
  );
  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // timebase runs only for a counted number of rising edges
  initial
  begin
    osc = 1'b0;
    forever
    begin
      #3;
      if (osc_left > 0)
      begin
        osc = ~osc;
        if (osc)
          osc_left--;
      end
    end
  end
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fails++;
      test_done();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] p, input logic [7:0] a, b);
    logic [7:0] rx;
    logic ak;
    u_mst.start_c();
    u_mst.xfer({rtc_pkg::DEV_ID_DEF, 1'b0}, 1'b1, rx, ak);
    chk({7'h00, ak}, 8'h00);
    u_mst.xfer({4'h0, p}, 1'b1, rx, ak);
    chk({7'h00, ak}, 8'h00);
    u_mst.xfer(a, 1'b1, rx, ak);
    chk({7'h00, ak}, 8'h00);
    u_mst.xfer(b, 1'b1, rx, ak);
    chk({7'h00, ak}, 8'h00);
    u_mst.stop_c();
  endtask
  task automatic rd(input logic [3:0] p);
    logic ak;
    u_mst.start_c();
    u_mst.xfer({rtc_pkg::DEV_ID_DEF, 1'b0}, 1'b1, r0, ak);
    u_mst.xfer({4'h0, p}, 1'b1, r0, ak);
    u_mst.start_c();
    u_mst.xfer({rtc_pkg::DEV_ID_DEF, 1'b1}, 1'b1, r0, ak);
    chk({7'h00, ak}, 8'h00);
    u_mst.xfer(8'hFF, 1'b0, r0, ak);
    u_mst.xfer(8'hFF, 1'b0, r1, ak);
    u_mst.xfer(8'hFF, 1'b1, r2, ak);
    u_mst.stop_c();
  endtask
  task automatic run_osc(input int e);
    osc_left = e;
    repeat (e * 6 / 40 + 20) @(posedge clk_sys_i);
    #2;
  endtask
  task automatic t_reset();
    repeat (8) @(posedge clk_sys_i);
    #2;
    chk({6'h00, sda_oe, a_oe}, 8'h00);
    chk({7'h00, b_oe}, 8'h01);
    chk({5'h00, sda_d, a_d, b_d}, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_seq();
    wr(4'h7, 8'h12, 8'h34);
    rd(4'h7);
    chk(r0, 8'h12);
    chk(r1, 8'h34);
    chk(r2, 8'h00);
    $display("t_seq done");
  endtask
  // write across the end of the map, then read across it
  task automatic t_wrap();
    wr(4'hF, 8'h00, 8'h45);
    rd(4'hF);
    chk(r0, 8'h00);
    chk(r1, 8'h45);
    chk(r2, 8'h00);
    $display("t_wrap done");
  endtask
  task automatic t_refuse();
    logic ak;
    u_mst.start_c();
    u_mst.xfer({rtc_pkg::DEV_ID_DEF ^ 7'h01, 1'b0}, 1'b1, r0, ak);
    chk({7'h00, ak}, 8'h01);
    u_mst.xfer(8'h00, 1'b1, r0, ak);
    chk({7'h00, ak}, 8'h01);
    u_mst.stop_c();
    $display("t_refuse done");
  endtask
  // three seconds from 45 reach the alarm value 48
  task automatic t_alarm();
    wr(4'h7, 8'h48, 8'h00);
    wr(4'hE, 8'h05, 8'hFF);
    run_osc(6 * H + H / 2);
    chk({7'h00, a_oe}, 8'h01);
    chk({7'h00, b_oe}, 8'h00);
    rd(4'h0);
    chk(r0, 8'h48);
    wr(4'hE, 8'h05, 8'h00);
    chk({7'h00, a_oe}, 8'h00);
    $display("t_alarm done");
  endtask
  task automatic t_square();
    int n;
    logic q;
    wr(4'hE, 8'h01, 8'hFF);
    n = 0;
    q = b_oe;
    osc_left = 4 * H;
    repeat (80)
    begin
      @(posedge clk_sys_i);
      #2;
      if (b_oe !== q)
        n++;
      q = b_oe;
    end
    chk(8'(n), 8'h04);
    chk({7'h00, a_oe}, 8'h00);
    $display("t_square done");
  endtask
  // shared mode: alarm 2 minute match at rollover drives the first pin
  task automatic t_shared();
    wr(4'hB, 8'h01, 8'h00);
    wr(4'h0, 8'h59, 8'h00);
    wr(4'hE, 8'h02, 8'h00);
    chk({7'h00, a_oe}, 8'h00);
    run_osc(H);
    chk({7'h00, a_oe}, 8'h01);
    rd(4'h0);
    chk(r0, 8'h00);
    chk(r1, 8'h01);
    $display("t_shared done");
  endtask
  initial
  begin
    fails = 0;
    num_checks = 0;
    nrst_i = 1'b0;
    osc_left = 4;
    repeat (20) @(posedge clk_sys_i);
    #2;
    nrst_i = 1'b1;
    t_reset();
    t_seq();
    t_wrap();
    t_refuse();
    t_alarm();
    t_square();
    t_shared();
    test_done();
  end
endmodule // test_rtc_serial_core
